// file: supply_clock_integrity_monitor.sv
`timescale 1ns/10ps
// Function
// - Hold reset while supply below hysteretic threshold.
// - Drive external reset pin low during it.
// - Low-supply reset only when option enabled.
// - Auxiliary monitor works only with option.
// - Auxiliary flag follows comparator in real time.
// - Bit 7 selects main supply or sense.
// - Enabled interrupt on every flag change.
// - Pending auxiliary interrupt cleared on service entry.
// - Fast rise gives no auxiliary rising interrupt.
// - Slow rise: enabling before crossing gives two.
// - Glitch filtering only while doubler enabled.
// - Lost main clock selects safe oscillator.
// - Safe clock sets flag, enabled interrupt raised.
// - Wait unchanged; interrupts wake wait, not halt.
// - Halt blocks register writes and holds safe flag, stops clock supervision.
// - Interrupt needs enable and cleared global mask.
// - Register resets to zero with documented layout.
// - Safe flag cleared by read after recovery.
// - Low-supply flag set by reset, write-zero clear.
// - Watchdog flag cleared by write or low-supply.
module supply_clock_integrity_monitor #(
  parameter int unsigned reset_delay_long = integrity_pkg::long_delay
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic lvr_option_in,
  input wire logic css_option_in,
  input wire logic pll_option_in,
  input wire logic long_delay_option_in,
  input wire logic supply_low_cmp_in,
  input wire logic aux_main_cmp_in,
  input wire logic aux_sense_cmp_in,
  input wire logic clock_loss_in,
  input wire logic osc_glitch_in,
  input wire logic watchdog_reset_in,
  input wire logic global_mask_in,
  input wire logic aux_irq_ack_in,
  input wire logic halt_enter_in,
  input wire logic wait_enter_in,
  input wire logic wake_irq_in,
  output logic [7:0] rdata_out,
  output logic reset_pin_n_out,
  output logic reset_pin_oe_out,
  output logic safe_clock_select_out,
  output logic glitch_block_out,
  output logic aux_irq_out,
  output logic clock_fail_irq_out,
  output logic wake_out
);
  localparam int unsigned sync_w = 4;
  localparam int unsigned cnt_w = 13;
  localparam logic [cnt_w-1:0] delay_s = cnt_w'(integrity_pkg::short_delay);
  localparam logic [cnt_w-1:0] delay_l = cnt_w'(reset_delay_long);

  ////////////////////////////////////////////////////////////////////////////////
  // Three-stage synchronisers; a change counts when stages two and three agree.
  logic [sync_w-1:0] raw;
  logic [sync_w-1:0] s1_reg;
  logic [sync_w-1:0] s2_reg;
  logic [sync_w-1:0] s3_reg;
  logic [sync_w-1:0] filt_reg;
  logic [sync_w-1:0] s1_next;
  logic [sync_w-1:0] s2_next;
  logic [sync_w-1:0] s3_next;
  logic [sync_w-1:0] filt_next;
  assign raw = {osc_glitch_in, clock_loss_in, aux_sense_cmp_in, aux_main_cmp_in};
  genvar gi;
  generate
    for (gi = 0; gi < sync_w; gi++) begin : g_sync
      always_comb begin
        s1_next[gi] = raw[gi];
        s2_next[gi] = s1_reg[gi];
        s3_next[gi] = s2_reg[gi];
        filt_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : filt_reg[gi];
      end
    end
  endgenerate
  // The supply chain presets high, so reset holds until a good supply is reported.
  logic low1_reg;
  logic low2_reg;
  logic low3_reg;
  logic lowf_reg;
  logic low1_next;
  logic low2_next;
  logic low3_next;
  logic lowf_next;
  always_comb begin
    low1_next = supply_low_cmp_in;
    low2_next = low1_reg;
    low3_next = low2_reg;
    lowf_next = (low2_reg == low3_reg) ? low3_reg : lowf_reg;
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      filt_reg <= '0;
      low1_reg <= 1'b1;
      low2_reg <= 1'b1;
      low3_reg <= 1'b1;
      lowf_reg <= 1'b1;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      filt_reg <= filt_next;
      low1_reg <= low1_next;
      low2_reg <= low2_next;
      low3_reg <= low3_next;
      lowf_reg <= lowf_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register, reset flags, power state and interrupt pending bits.
  integrity_pkg::pwr_state_t pwr_reg, pwr_next;
  logic src_sel_reg;
  logic src_sel_next;
  logic aux_ie_reg;
  logic aux_ie_next;
  logic cf_ie_reg;
  logic cf_ie_next;
  logic safe_reg;
  logic safe_next;
  logic lvr_flag_reg;
  logic lvr_flag_next;
  logic wdg_flag_reg;
  logic wdg_flag_next;
  logic aux_prev_reg;
  logic aux_prev_next;
  logic aux_pend_reg;
  logic aux_pend_next;
  logic cf_pend_reg;
  logic cf_pend_next;
  logic in_lvr_reg;
  logic in_lvr_next;
  logic [cnt_w-1:0] dly_reg;
  logic [cnt_w-1:0] dly_next;
  logic [7:0] rdata_next;
  logic lvr_active;
  logic aux_live;
  logic aux_flag;
  logic halted;
  logic clk_lost;
  logic do_write;
  logic aux_irq_next;
  logic cf_irq_next;
  logic wake_next;
  logic pin_n_next;
  logic pin_oe_next;
  logic safe_sel_next;
  logic glitch_next;

  always_comb begin
    lvr_active = lvr_option_in & lowf_reg;
    halted = (pwr_reg == integrity_pkg::pwr_halt);
    aux_live = lvr_option_in & ~in_lvr_reg;
    aux_flag = aux_live & (src_sel_reg ? filt_reg[1] : filt_reg[0]);
    clk_lost = css_option_in & ~halted & filt_reg[2];
    do_write = write_in & ~halted;
    src_sel_next = src_sel_reg;
    aux_ie_next = aux_ie_reg;
    cf_ie_next = cf_ie_reg;
    lvr_flag_next = lvr_flag_reg;
    wdg_flag_next = wdg_flag_reg;
    if (do_write) begin
      src_sel_next = wdata_in[integrity_pkg::bit_src_sel] & lvr_option_in;
      aux_ie_next = wdata_in[integrity_pkg::bit_aux_ie] & lvr_option_in;
      cf_ie_next = wdata_in[integrity_pkg::bit_cf_ie];
      if (!wdata_in[integrity_pkg::bit_lvr_flag]) begin
        lvr_flag_next = 1'b0;
      end
      if (!wdata_in[integrity_pkg::bit_wdg_flag]) begin
        wdg_flag_next = 1'b0;
      end
    end
    if (watchdog_reset_in) begin
      wdg_flag_next = 1'b1;
    end
    if (lvr_active) begin
      lvr_flag_next = 1'b1;
      wdg_flag_next = 1'b0;
      src_sel_next = 1'b0;
      aux_ie_next = 1'b0;
      cf_ie_next = 1'b0;
    end
    // Safe flag is set while the clock is lost; a read clears it only after recovery.
    safe_next = safe_reg;
    if (read_in && !clk_lost) begin
      safe_next = 1'b0;
    end
    if (clk_lost) begin
      safe_next = 1'b1;
    end
    if (!css_option_in) begin
      safe_next = 1'b0;
    end
    if (halted) begin
      safe_next = safe_reg;
    end
    // Rising supply is held in reset delay; no rising crossing interrupt then.
    in_lvr_next = in_lvr_reg;
    dly_next = dly_reg;
    if (lvr_active) begin
      in_lvr_next = 1'b1;
      dly_next = long_delay_option_in ? delay_l : delay_s;
    end else if (in_lvr_reg) begin
      if (dly_reg <= cnt_w'(1)) in_lvr_next = 1'b0;
      else dly_next = dly_reg - cnt_w'(1);
    end
    // The previous flag tracks even when disabled, so enabling compares against now.
    aux_prev_next = aux_flag;
    aux_pend_next = aux_pend_reg;
    if (aux_irq_ack_in) aux_pend_next = 1'b0;
    if (do_write && wdata_in[integrity_pkg::bit_aux_ie] && !aux_ie_reg && aux_live && aux_flag) begin
      aux_pend_next = 1'b1;
    end
    if (aux_ie_reg && aux_live && (aux_flag != aux_prev_reg)) aux_pend_next = 1'b1;
    if (!aux_ie_next || !aux_live) aux_pend_next = 1'b0;
    cf_pend_next = safe_next & cf_ie_reg & css_option_in;
    aux_irq_next = aux_pend_next & ~global_mask_in;
    cf_irq_next = cf_pend_next & ~global_mask_in;
    // The reset pin is open drain: its level is low except while rstn_in holds reset, and the enable decides.
    pin_n_next = 1'b0;
    pin_oe_next = lvr_active;
    safe_sel_next = clk_lost;
    glitch_next = pll_option_in & filt_reg[3] & ~halted;
    pwr_next = pwr_reg;
    wake_next = 1'b0;
    case (pwr_reg)
      integrity_pkg::pwr_run: begin
        if (halt_enter_in) pwr_next = integrity_pkg::pwr_halt;
        else if (wait_enter_in) pwr_next = integrity_pkg::pwr_wait;
      end
      integrity_pkg::pwr_wait: begin
        if (aux_irq_next || cf_irq_next) begin
          pwr_next = integrity_pkg::pwr_run;
          wake_next = 1'b1;
        end
      end
      integrity_pkg::pwr_halt: begin
        if (wake_irq_in) pwr_next = integrity_pkg::pwr_run;
      end
      default: pwr_next = integrity_pkg::pwr_run;
    endcase
    rdata_next = 8'h00;
    if (read_in) begin
      rdata_next[integrity_pkg::bit_src_sel] = src_sel_reg;
      rdata_next[integrity_pkg::bit_aux_ie] = aux_ie_reg;
      rdata_next[integrity_pkg::bit_aux_flag] = aux_flag;
      rdata_next[integrity_pkg::bit_lvr_flag] = lvr_flag_reg;
      rdata_next[integrity_pkg::bit_cf_ie] = cf_ie_reg;
      rdata_next[integrity_pkg::bit_safe_flag] = safe_reg;
      rdata_next[integrity_pkg::bit_wdg_flag] = wdg_flag_reg;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      src_sel_reg <= integrity_pkg::reg_reset[integrity_pkg::bit_src_sel];
      aux_ie_reg <= integrity_pkg::reg_reset[integrity_pkg::bit_aux_ie];
      cf_ie_reg <= integrity_pkg::reg_reset[integrity_pkg::bit_cf_ie];
      safe_reg <= integrity_pkg::reg_reset[integrity_pkg::bit_safe_flag];
      lvr_flag_reg <= integrity_pkg::reg_reset[integrity_pkg::bit_lvr_flag];
      wdg_flag_reg <= integrity_pkg::reg_reset[integrity_pkg::bit_wdg_flag];
      aux_prev_reg <= 1'b0;
      aux_pend_reg <= 1'b0;
      cf_pend_reg <= 1'b0;
      in_lvr_reg <= 1'b1;
      dly_reg <= delay_s;
      pwr_reg <= integrity_pkg::pwr_run;
      rdata_out <= 8'h00;
      reset_pin_n_out <= 1'b1;
      reset_pin_oe_out <= 1'b0;
      safe_clock_select_out <= 1'b0;
      glitch_block_out <= 1'b0;
      aux_irq_out <= 1'b0;
      clock_fail_irq_out <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      src_sel_reg <= src_sel_next;
      aux_ie_reg <= aux_ie_next;
      cf_ie_reg <= cf_ie_next;
      safe_reg <= safe_next;
      lvr_flag_reg <= lvr_flag_next;
      wdg_flag_reg <= wdg_flag_next;
      aux_prev_reg <= aux_prev_next;
      aux_pend_reg <= aux_pend_next;
      cf_pend_reg <= cf_pend_next;
      in_lvr_reg <= in_lvr_next;
      dly_reg <= dly_next;
      pwr_reg <= pwr_next;
      rdata_out <= rdata_next;
      reset_pin_n_out <= pin_n_next;
      reset_pin_oe_out <= pin_oe_next;
      safe_clock_select_out <= safe_sel_next;
      glitch_block_out <= glitch_next;
      aux_irq_out <= aux_irq_next;
      clock_fail_irq_out <= cf_irq_next;
      wake_out <= wake_next;
    end
  end
endmodule

// file: integrity_pkg.sv
package integrity_pkg;
  localparam int unsigned clk_mhz = 250;
  localparam logic [7:0] reg_reset = 8'h00;
  localparam int unsigned bit_src_sel = 7;
  localparam int unsigned bit_aux_ie = 6;
  localparam int unsigned bit_aux_flag = 5;
  localparam int unsigned bit_lvr_flag = 4;
  localparam int unsigned bit_reserved = 3;
  localparam int unsigned bit_cf_ie = 2;
  localparam int unsigned bit_safe_flag = 1;
  localparam int unsigned bit_wdg_flag = 0;
  localparam logic [7:0] sw_write_mask = 8'hc4;
  localparam int unsigned short_delay = 256;
  localparam int unsigned long_delay = 4096;
  typedef enum logic [1:0] {
    pwr_run = 2'b00,
    pwr_wait = 2'b01,
    pwr_halt = 2'b11
  } pwr_state_t;
endpackage

// file: integrity_asserts.sv
`timescale 1ns/10ps
module integrity_asserts (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [7:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic lvr_option_in,
  input wire logic css_option_in,
  input wire logic pll_option_in,
  input wire logic supply_low_cmp_in,
  input wire logic clock_loss_in,
  input wire logic osc_glitch_in,
  input wire logic global_mask_in,
  input wire logic aux_irq_ack_in,
  input wire logic [7:0] rdata_out,
  input wire logic reset_pin_n_out,
  input wire logic reset_pin_oe_out,
  input wire logic safe_clock_select_out,
  input wire logic glitch_block_out,
  input wire logic aux_irq_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_wr_rd;
    write_in ##1 read_in;
  endsequence
  a_read_idle_zero: assert property (!$past(read_in) |-> rdata_out == 8'h00)
    else $error("read data without read");
  a_reserved_bit_zero: assert property (rdata_out[3] == 1'b0)
    else $error("reserved bit set");
  a_pin_level_low: assert property ($past(rstn_in) |-> !reset_pin_n_out)
    else $error("reset pin level high");
  a_low_supply_drive: assert property ((lvr_option_in && $rose(supply_low_cmp_in)) |-> ##[2:6] reset_pin_oe_out)
    else $error("reset pin not driven");
  a_lvr_off_quiet: assert property (!$past(lvr_option_in) |-> !reset_pin_oe_out)
    else $error("reset pin driven without option");
  a_safe_clock_on: assert property ((css_option_in && $rose(clock_loss_in)) |-> ##[2:6] safe_clock_select_out)
    else $error("safe clock not selected");
  a_css_off_quiet: assert property (!$past(css_option_in) |-> !safe_clock_select_out)
    else $error("safe clock without option");
  a_safe_clock_off: assert property ($fell(clock_loss_in) |-> ##[2:6] !safe_clock_select_out)
    else $error("main clock not restored");
  a_glitch_filter_on: assert property ((pll_option_in && $rose(osc_glitch_in)) |-> ##[2:6] glitch_block_out)
    else $error("glitch not filtered");
  a_mask_blocks_irq: assert property (aux_irq_out |-> !$past(global_mask_in))
    else $error("irq while masked");
  a_ack_clears_irq: assert property (aux_irq_ack_in |-> ##2 !aux_irq_out)
    else $error("irq not cleared");
  a_write_read_back: assert property (s_wr_rd |=> rdata_out[7:6] == $past(wdata_in[7:6], 2)
    && rdata_out[2] == $past(wdata_in[2], 2))
    else $error("written bits lost");
endmodule
bind supply_clock_integrity_monitor integrity_asserts chk (.clk_in(clk_in), .rstn_in(rstn_in),
  .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .supply_low_cmp_in(supply_low_cmp_in),
  .lvr_option_in(lvr_option_in), .css_option_in(css_option_in), .pll_option_in(pll_option_in),
  .clock_loss_in(clock_loss_in), .osc_glitch_in(osc_glitch_in), .global_mask_in(global_mask_in),
  .aux_irq_ack_in(aux_irq_ack_in), .rdata_out(rdata_out), .reset_pin_n_out(reset_pin_n_out),
  .reset_pin_oe_out(reset_pin_oe_out), .safe_clock_select_out(safe_clock_select_out),
  .glitch_block_out(glitch_block_out), .aux_irq_out(aux_irq_out));

// file: integrity_partner.sv
`timescale 1ns/10ps
module integrity_partner (
  input wire logic clk_in,
  input wire logic [7:0] supply_level_in,
  input wire logic [3:0] cmd_in,
  output logic supply_low_out,
  output logic [3:0] analog_out
);
  // Between the two levels the comparator keeps its last decision.
  localparam logic [7:0] rise_level = 8'h80;
  localparam logic [7:0] fall_level = 8'h70;
  initial supply_low_out = 1'b0;
  initial analog_out = 4'h0;
  always @(posedge clk_in) begin
    if (supply_level_in < fall_level) supply_low_out <= 1'b1;
    else if (supply_level_in >= rise_level) supply_low_out <= 1'b0;
    analog_out <= cmd_in;
  end
endmodule

// file: supply_clock_integrity_monitor_bench.sv
`timescale 1ns/10ps
module supply_clock_integrity_monitor_bench;
  logic clk_in = 0, rstn_in = 0, write_in = 0, read_in = 0, wdog = 0, mask = 0, ack = 0;
  logic halt = 0, waitp = 0, wake = 0, seen = 0, opt_lvr = 1, opt_css = 1, opt_pll = 1;
  logic [7:0] wdata = 8'h00, lvl = 8'hff;
  logic [3:0] cmd = 4'h0;
  wire logic low;
  wire logic [3:0] ana;
  wire logic [7:0] rdata_out;
  wire logic pin_n, oe, sel, gl, airq, cirq, wake_out;
  int mismatches = 0, n_checks = 0;
  integrity_partner part (.clk_in(clk_in), .supply_level_in(lvl), .cmd_in(cmd), .supply_low_out(low),
    .analog_out(ana));
  supply_clock_integrity_monitor #(.reset_delay_long(16)) uut (.clk_in(clk_in), .rstn_in(rstn_in),
    .wdata_in(wdata), .write_in(write_in), .read_in(read_in), .lvr_option_in(opt_lvr), .css_option_in(opt_css),
    .pll_option_in(opt_pll), .long_delay_option_in(1'b1), .supply_low_cmp_in(low), .aux_main_cmp_in(ana[0]),
    .aux_sense_cmp_in(ana[1]), .clock_loss_in(ana[2]), .osc_glitch_in(ana[3]), .watchdog_reset_in(wdog),
    .global_mask_in(mask), .aux_irq_ack_in(ack), .halt_enter_in(halt), .wait_enter_in(waitp),
    .wake_irq_in(wake), .rdata_out(rdata_out), .reset_pin_n_out(pin_n), .reset_pin_oe_out(oe),
    .safe_clock_select_out(sel), .glitch_block_out(gl), .aux_irq_out(airq), .clock_fail_irq_out(cirq),
    .wake_out(wake_out));
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task end_sim;
    if (mismatches == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task wr(input logic [7:0] v);
    @(posedge clk_in) {write_in, wdata} <= {1'b1, v};
    @(posedge clk_in) write_in <= 1'b0;
  endtask
  // The read data are taken in the cycle after the one-cycle read strobe.
  task rdx(input logic [7:0] e, input logic [7:0] m = 8'hff);
    @(posedge clk_in) read_in <= 1'b1;
    @(posedge clk_in) read_in <= 1'b0;
    #1 chk("rdata", e, rdata_out & m);
  endtask
  task wrrd(input logic [7:0] v, input logic [7:0] e);
    @(posedge clk_in) {write_in, wdata} <= {1'b1, v};
    @(posedge clk_in) {write_in, read_in} <= 2'b01;
    @(posedge clk_in) read_in <= 1'b0;
    #1 chk("rdata", e, rdata_out);
  endtask
  task ackp;
    @(posedge clk_in) ack <= 1'b1;
    @(posedge clk_in) ack <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_regs;
    cyc(8);
    chk("oe", 8'h00, 8'(oe));
    rdx(8'h00, 8'hef);
    wr(8'h00);
    wrrd(8'hff, 8'hc4);
    wrrd(8'h3b, 8'h00);
  endtask
  task t_aux;
    wr(8'h40);
    @(posedge clk_in) cmd <= 4'h1;
    cyc(8);
    chk("aux_irq", 8'h01, 8'(airq));
    rdx(8'h60);
    ackp();
    cyc(3);
    chk("aux_irq", 8'h00, 8'(airq));
    @(posedge clk_in) {mask, cmd} <= {1'b1, 4'h0};
    cyc(8);
    chk("aux_irq", 8'h00, 8'(airq));
    @(posedge clk_in) mask <= 1'b0;
    cyc(3);
    chk("aux_irq", 8'h01, 8'(airq));
    ackp();
    wr(8'h00);
    @(posedge clk_in) cmd <= 4'h1;
    cyc(8);
    chk("aux_irq", 8'h00, 8'(airq));
    wr(8'h40);
    cyc(3);
    chk("aux_irq", 8'h01, 8'(airq));
    ackp();
    wr(8'hc0);
    cyc(8);
    rdx(8'hc0);
    @(posedge clk_in) cmd <= 4'h3;
    cyc(8);
    rdx(8'he0);
    @(posedge clk_in) cmd <= 4'h0;
    wr(8'h00);
    ackp();
  endtask
  task t_css;
    wr(8'h04);
    @(posedge clk_in) cmd <= 4'h4;
    cyc(8);
    chk("safe_sel", 8'h01, 8'(sel));
    chk("cf_irq", 8'h01, 8'(cirq));
    rdx(8'h06);
    @(posedge clk_in) cmd <= 4'h8;
    cyc(8);
    chk("safe_sel", 8'h00, 8'(sel));
    chk("glitch", 8'h01, 8'(gl));
    rdx(8'h06);
    rdx(8'h04);
    @(posedge clk_in) cmd <= 4'h0;
  endtask
  task t_lvd;
    wr(8'h00);
    @(posedge clk_in) wdog <= 1'b1;
    @(posedge clk_in) wdog <= 1'b0;
    cyc(2);
    rdx(8'h01);
    @(posedge clk_in) lvl <= 8'h60;
    cyc(8);
    chk("oe", 8'h01, 8'(oe));
    @(posedge clk_in) lvl <= 8'h78;
    cyc(8);
    chk("oe", 8'h01, 8'(oe));
    @(posedge clk_in) lvl <= 8'hff;
    cyc(8);
    chk("oe", 8'h00, 8'(oe));
    rdx(8'h10);
    @(posedge clk_in) wdog <= 1'b1;
    @(posedge clk_in) wdog <= 1'b0;
    cyc(2);
    rdx(8'h11);
    wr(8'h00);
    rdx(8'h00);
  endtask
  task t_power;
    cyc(20);
    wr(8'h04);
    @(posedge clk_in) halt <= 1'b1;
    @(posedge clk_in) halt <= 1'b0;
    wr(8'h00);
    cyc(2);
    @(posedge clk_in) wake <= 1'b1;
    @(posedge clk_in) wake <= 1'b0;
    cyc(2);
    rdx(8'h04);
    @(posedge clk_in) waitp <= 1'b1;
    @(posedge clk_in) waitp <= 1'b0;
    wr(8'h40);
    @(posedge clk_in) cmd <= 4'h1;
    repeat (12) begin
      cyc(1);
      if (wake_out === 1'b1) seen = 1'b1;
    end
    chk("wake", 8'h01, 8'(seen));
  endtask
  task t_options;
    wr(8'h00);
    @(posedge clk_in) {opt_lvr, opt_css, opt_pll, lvl, cmd} <= {3'h0, 8'h60, 4'hc};
    cyc(8);
    chk("oe", 8'h00, 8'(oe));
    chk("safe_sel", 8'h00, 8'(sel));
    chk("glitch", 8'h00, 8'(gl));
    wr(8'hc4);
    rdx(8'h04);
  endtask
  initial begin
    repeat (6) @(posedge clk_in);
    rstn_in <= 1'b1;
    t_regs();
    t_aux();
    t_css();
    t_lvd();
    t_power();
    t_options();
    end_sim();
  end
  initial begin
    #20000;
    mismatches++;
    end_sim();
  end
endmodule
